// *** dbsp_defines.vh ***
`ifndef DBSP_DEFINES_VH
`define DBSP_DEFINES_VH

// Register word addresses on the Avalon-MM slave (matched against avs_address[3:0])
`define DBSP_ADDR_STATUS     4'h0
`define DBSP_ADDR_COMMAND    4'h1
`define DBSP_ADDR_ADDR_LOW   4'h2
`define DBSP_ADDR_ADDR_HIGH  4'h3
`define DBSP_ADDR_DATA       4'h4
`define DBSP_ADDR_CONFIG     4'h5
`define DBSP_ADDR_NVSTAT     4'h6

// Field positions
`define DBSP_STAT_BUSY       2
`define DBSP_STAT_DISABLED   7
`define DBSP_CMD_IRQ_SEL     7
`define DBSP_CFG_ENABLE      6
`define DBSP_CFG_OVL_B       1
`define DBSP_CFG_OVL_A       0

// Reset values
`define DBSP_CONFIG_RST      8'h00
`define DBSP_BYTE_RST        8'h00

// Command codes (low seven bits of the command byte)
`define DBSP_CMD_CHIP_ERASE  7'h01
`define DBSP_CMD_BLK_ERASE   7'h0D
`define DBSP_CMD_SEC_ERASE   7'h0B
`define DBSP_CMD_PROGRAM     7'h0E
`define DBSP_CMD_VERIFY      7'h0C
`define DBSP_CMD_LOCK_ONE    7'h0F
`define DBSP_CMD_LOCK_TWO    7'h03
`define DBSP_CMD_LOCK_THREE  7'h05
`define DBSP_CMD_OVERLAY     7'h09
`define DBSP_CMD_CLK_DOUBLE  7'h08

// Key values in the data and address-high registers
`define DBSP_KEY_ERASE       8'h55
`define DBSP_KEY_CFG         8'hAA
`define DBSP_KEY_OVL_A       8'h5A
`define DBSP_KEY_OVL_B       8'hAA
`define DBSP_KEY_CLK         8'h55
`define DBSP_BLK1_TOP        3'h7
`define DBSP_BLK0_TOP        3'h0

// Flash array operation select, one-hot
`define DBSP_OP_W            6
`define DBSP_OP_CHIP         6'h01
`define DBSP_OP_BLOCK        6'h02
`define DBSP_OP_SECTOR       6'h04
`define DBSP_OP_PROGRAM      6'h08
`define DBSP_OP_READ         6'h10
`define DBSP_OP_CFG          6'h20

// Code source encoding on exec_src
`define DBSP_SRC_BLK0        2'h0
`define DBSP_SRC_BLK1        2'h1
`define DBSP_SRC_EXT         2'h2

`endif

// *** dbsp_flash_sequencer.v ***
`timescale 1ns/1ns
`include "dbsp_defines.vh"

// Operation
// - Commands are ignored while the programming enable bit is clear.
// - Command register write starts the operation using prepared address and data.
// - Commands aimed at a security-locked block are refused.
// - Block 0 code targets block 1 and reverse; external code targets by address.
// - Access pin and two overlay bits decide mapping of block 1 over low 8K.
// - Core and controller use one clock; oscillator runs only during an operation.
// - 01H/55H erases both blocks externally, not at level 4, clearing locks too.
// - 0DH/55H erases a block; top bit 0 block 0, top bits 111b block 1.
// - 0BH erases the 128-byte sector at the address registers.
// - 0EH programs the data register byte at the address registers.
// - 0CH returns the addressed byte in data register, no busy, no interrupt.
// - 0FH/03H/05H with AAH program lock bits once; effect is immediate.
// - 09H/AAH/5AH programs overlay bit a; bank select changes only at reset.
// - 09H/AAH/AAH programs overlay bit b; mirrored config bit updates at reset.
// - 08H/AAH/55H switches the processor from 12 to 6 clocks per cycle.
// - Status bit 2 reads 1 during an operation and 0 when ready.
// - Code reads aimed at a busy flash block fail.
// - Command bit 7 makes completion raise interrupt one internally; pin ignored then.
// - Disable pin low during reset disables all self-programming commands.
module dbsp_flash_sequencer (
   input  wire                  clk,                        // 250 MHz clock
   input  wire                  rst_n,                      // Device reset, sync, active low
   input  wire                  por_n,                      // Power-on reset for kept bits
   input  wire [4:0]            avs_address,                // Avalon word address
   input  wire                  avs_read,                   // Avalon read
   input  wire                  avs_write,                  // Avalon write
   input  wire [31:0]           avs_writedata,              // Avalon write data
   output reg  [31:0]           avs_readdata,               // Avalon read data
   output reg                   avs_waitrequest,            // Avalon wait
   input  wire [1:0]            exec_src,                   // Where issuing code runs
   input  wire                  external_access_pin_n,      // Access pin, low = external
   input  wire                  self_program_disable_pin_n, // Disable strap, low = off
   input  wire                  ext_irq_one_pin_n,          // Interrupt-one pin
   input  wire                  code_rd_req,                // Code read request pulse
   input  wire                  code_rd_block,              // Block of that code read
   output reg                   code_rd_fail,               // Code read refused
   output reg  [`DBSP_OP_W-1:0] arr_op,                     // Array operation, one-hot
   output reg                   arr_start,                  // Array start pulse
   output reg                   arr_block,                  // Array target block
   output reg  [15:0]           arr_addr,                   // Array byte address
   output reg  [7:0]            arr_wdata,                  // Array program data
   input  wire                  arr_done,                   // Array finished pulse
   input  wire [7:0]            arr_rdata,                  // Array read data
   output reg                   osc_en,                     // Internal oscillator enable
   output reg                   ext_irq_one,                // Interrupt one to controller
   output reg                   overlay_map,                // Block 1 over low 8K
   output reg                   boot_bank_select,           // Bank select in force
   output reg                   clock_double                // 6 clocks per cycle
);

   localparam ST_IDLE = 2'b01;
   localparam ST_RUN  = 2'b10;

   reg [1:0]  state_r;
   reg [7:0]  flash_command_reg;
   reg [7:0]  flash_addr_low_reg;
   reg [7:0]  flash_addr_high_reg;
   reg [7:0]  flash_data_reg;
   reg [7:0]  flash_config_reg;
   reg        busy_r;
   reg        irq_sel_r;
   reg        disabled_r;
   reg        chip_op_r;
   reg [6:0]  effect_r;
   // Kept bits survive device reset and clear only on power-on or chip erase
   reg        lock_one_r;
   reg        lock_two_r;
   reg        lock_three_r;
   reg        overlay_config_bit_a;
   reg        overlay_config_bit_b;
   reg        clk_double_nv_r;
   reg [2:0]  ea_sync_r;
   reg        ea_n_r;
   reg [2:0]  dis_sync_r;
   reg        dis_n_r;
   reg [2:0]  irq_sync_r;
   reg        irq_pin_n_r;

   wire       bus_req  = avs_read | avs_write;
   wire       wr_take  = avs_write & ~avs_waitrequest;
   wire       cmd_wr   = wr_take & (avs_address[3:0] == `DBSP_ADDR_COMMAND);
   wire [6:0] cmd_code = avs_writedata[6:0];
   wire       lvl4     = lock_one_r & lock_two_r & lock_three_r;
   wire       ext_exec = (exec_src == `DBSP_SRC_EXT) & ~ea_n_r;
   wire [7:0] cfg_rst  = `DBSP_CONFIG_RST;

   // Lock two guards block 0, lock three guards block 1
   function blk_locked;
      input blk;
      begin
         blk_locked = blk ? lock_three_r : lock_two_r;
      end
   endfunction

   // Returns {valid, block} for a byte-addressed command
   function [1:0] target_of;
      input [1:0] src;
      input [7:0] ah;
      input       map;
      begin
         case (src)
            `DBSP_SRC_BLK0: target_of = 2'b11;
            `DBSP_SRC_BLK1: target_of = 2'b10;
            `DBSP_SRC_EXT: begin
               if (ah[7:5] == `DBSP_BLK1_TOP)
                  target_of = 2'b11;
               else if (map && ah[7:5] == `DBSP_BLK0_TOP)
                  target_of = 2'b11;
               else
                  target_of = 2'b10;
            end
            default: target_of = 2'b00;
         endcase
      end
   endfunction

   // Command decode: start, array op, target, deferred effect
   reg                  go_nxt;
   reg [`DBSP_OP_W-1:0] op_nxt;
   reg                  blk_nxt;
   reg [6:0]            eff_nxt;
   reg [1:0]            tgt;
   always @* begin
      go_nxt  = 1'b0;
      op_nxt  = `DBSP_OP_READ;
      eff_nxt = 7'h00;
      tgt     = target_of(exec_src, flash_addr_high_reg, overlay_map);
      blk_nxt = tgt[0];
      case (cmd_code)
         `DBSP_CMD_CHIP_ERASE: begin
            go_nxt  = (flash_data_reg == `DBSP_KEY_ERASE) & ext_exec & ~lvl4;
            op_nxt  = `DBSP_OP_CHIP;
            eff_nxt = 7'h40;
         end
         `DBSP_CMD_BLK_ERASE: begin
            if (exec_src == `DBSP_SRC_EXT) begin
               blk_nxt = flash_addr_high_reg[7];
               tgt[1]  = ~flash_addr_high_reg[7] |
                         (flash_addr_high_reg[7:5] == `DBSP_BLK1_TOP);
            end
            go_nxt = (flash_data_reg == `DBSP_KEY_ERASE) & tgt[1] & ~blk_locked(blk_nxt);
            op_nxt = `DBSP_OP_BLOCK;
         end
         `DBSP_CMD_SEC_ERASE: begin
            go_nxt = tgt[1] & ~blk_locked(blk_nxt);
            op_nxt = `DBSP_OP_SECTOR;
         end
         `DBSP_CMD_PROGRAM: begin
            go_nxt = tgt[1] & ~blk_locked(blk_nxt);
            op_nxt = `DBSP_OP_PROGRAM;
         end
         `DBSP_CMD_VERIFY: begin
            go_nxt = tgt[1] & ~blk_locked(blk_nxt);
            op_nxt = `DBSP_OP_READ;
         end
         `DBSP_CMD_LOCK_ONE: begin
            go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) & ~lock_one_r;
            op_nxt  = `DBSP_OP_CFG;
            eff_nxt = 7'h01;
         end
         `DBSP_CMD_LOCK_TWO: begin
            go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) & ~lock_two_r;
            op_nxt  = `DBSP_OP_CFG;
            eff_nxt = 7'h02;
         end
         `DBSP_CMD_LOCK_THREE: begin
            go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) & ~lock_three_r;
            op_nxt  = `DBSP_OP_CFG;
            eff_nxt = 7'h04;
         end
         `DBSP_CMD_OVERLAY: begin
            op_nxt = `DBSP_OP_CFG;
            if (flash_addr_high_reg == `DBSP_KEY_OVL_A) begin
               go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) & ~overlay_config_bit_a;
               eff_nxt = 7'h08;
            end else if (flash_addr_high_reg == `DBSP_KEY_OVL_B) begin
               go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) & ~overlay_config_bit_b;
               eff_nxt = 7'h10;
            end
         end
         `DBSP_CMD_CLK_DOUBLE: begin
            go_nxt  = (flash_data_reg == `DBSP_KEY_CFG) &
                      (flash_addr_high_reg == `DBSP_KEY_CLK);
            op_nxt  = `DBSP_OP_CFG;
            eff_nxt = 7'h20;
         end
         default: go_nxt = 1'b0;
      endcase
      // Enable bit, reset strap and a running operation gate everything
      go_nxt = go_nxt & flash_config_reg[`DBSP_CFG_ENABLE] & ~disabled_r &
               (state_r == ST_IDLE);
   end

   wire start   = cmd_wr & go_nxt;
   wire finish  = (state_r == ST_RUN) & arr_done;
   wire is_read = (arr_op == `DBSP_OP_READ);

   // Pin synchronisers: a change counts once stages two and three agree
   always @(posedge clk) begin
      ea_sync_r  <= {ea_sync_r[1:0], external_access_pin_n};
      dis_sync_r <= {dis_sync_r[1:0], self_program_disable_pin_n};
      irq_sync_r <= {irq_sync_r[1:0], ext_irq_one_pin_n};
      // Strap filter runs through reset so the captured value has settled
      if (dis_sync_r[1] == dis_sync_r[2])
         dis_n_r <= dis_sync_r[2];
      if (!rst_n) begin
         ea_n_r      <= 1'b1;
         irq_pin_n_r <= 1'b1;
      end else begin
         if (ea_sync_r[1] == ea_sync_r[2])
            ea_n_r <= ea_sync_r[2];
         if (irq_sync_r[1] == irq_sync_r[2])
            irq_pin_n_r <= irq_sync_r[2];
      end
   end

   // Avalon slave: one wait cycle, then the answer
   always @(posedge clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            case (avs_address[3:0])
               `DBSP_ADDR_STATUS:
                  avs_readdata <= {24'h0, disabled_r, 4'h0, busy_r, 2'h0};
               `DBSP_ADDR_COMMAND:   avs_readdata <= {24'h0, flash_command_reg};
               `DBSP_ADDR_ADDR_LOW:  avs_readdata <= {24'h0, flash_addr_low_reg};
               `DBSP_ADDR_ADDR_HIGH: avs_readdata <= {24'h0, flash_addr_high_reg};
               `DBSP_ADDR_DATA:      avs_readdata <= {24'h0, flash_data_reg};
               `DBSP_ADDR_CONFIG:    avs_readdata <= {24'h0, flash_config_reg};
               `DBSP_ADDR_NVSTAT:
                  avs_readdata <= {24'h0, boot_bank_select, clock_double,
                                   overlay_config_bit_b, overlay_config_bit_a,
                                   lvl4, lock_three_r, lock_two_r, lock_one_r};
               default: avs_readdata <= 32'h0;
            endcase
         end
      end
   end

   // Mailbox registers and strap capture
   always @(posedge clk) begin
      if (!rst_n) begin
         flash_command_reg   <= `DBSP_BYTE_RST;
         flash_addr_low_reg  <= `DBSP_BYTE_RST;
         flash_addr_high_reg <= `DBSP_BYTE_RST;
         flash_data_reg      <= `DBSP_BYTE_RST;
         // Overlay bit b reaches the config mirror only here, at reset
         flash_config_reg    <= {cfg_rst[7:2], overlay_config_bit_b, cfg_rst[0]};
         boot_bank_select    <= overlay_config_bit_a;
         disabled_r          <= ~dis_n_r;
      end else begin
         if (wr_take) begin
            case (avs_address[3:0])
               `DBSP_ADDR_COMMAND:   flash_command_reg   <= avs_writedata[7:0];
               `DBSP_ADDR_ADDR_LOW:  flash_addr_low_reg  <= avs_writedata[7:0];
               `DBSP_ADDR_ADDR_HIGH: flash_addr_high_reg <= avs_writedata[7:0];
               `DBSP_ADDR_DATA:      flash_data_reg      <= avs_writedata[7:0];
               `DBSP_ADDR_CONFIG:    flash_config_reg    <= avs_writedata[7:0];
               default: flash_command_reg <= flash_command_reg;
            endcase
         end
         // Verify result wins over a bus write in the same cycle
         if (finish && is_read)
            flash_data_reg <= arr_rdata;
      end
   end

   // Sequencer
   always @(posedge clk) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         busy_r    <= 1'b0;
         irq_sel_r <= 1'b0;
         chip_op_r <= 1'b0;
         effect_r  <= 7'h00;
         arr_op    <= `DBSP_OP_READ;
         arr_start <= 1'b0;
         arr_block <= 1'b0;
         arr_addr  <= 16'h0;
         arr_wdata <= 8'h00;
         osc_en    <= 1'b0;
      end else begin
         arr_start <= start;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r   <= ST_RUN;
                  arr_op    <= op_nxt;
                  arr_block <= blk_nxt;
                  arr_addr  <= {flash_addr_high_reg, flash_addr_low_reg};
                  arr_wdata <= flash_data_reg;
                  effect_r  <= eff_nxt;
                  chip_op_r <= (op_nxt == `DBSP_OP_CHIP);
                  irq_sel_r <= avs_writedata[`DBSP_CMD_IRQ_SEL];
                  busy_r    <= (op_nxt != `DBSP_OP_READ);
                  osc_en    <= (op_nxt != `DBSP_OP_READ);
               end
            end
            ST_RUN: begin
               if (arr_done) begin
                  state_r <= ST_IDLE;
                  busy_r  <= 1'b0;
                  osc_en  <= 1'b0;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Kept configuration bits
   always @(posedge clk) begin
      if (!por_n) begin
         lock_one_r           <= 1'b0;
         lock_two_r           <= 1'b0;
         lock_three_r         <= 1'b0;
         overlay_config_bit_a <= 1'b0;
         overlay_config_bit_b <= 1'b0;
         clk_double_nv_r      <= 1'b0;
      end else if (finish) begin
         if (effect_r[6]) begin
            lock_one_r           <= 1'b0;
            lock_two_r           <= 1'b0;
            lock_three_r         <= 1'b0;
            overlay_config_bit_a <= 1'b0;
            overlay_config_bit_b <= 1'b0;
         end
         if (effect_r[0])
            lock_one_r <= 1'b1;
         if (effect_r[1])
            lock_two_r <= 1'b1;
         if (effect_r[2])
            lock_three_r <= 1'b1;
         if (effect_r[3])
            overlay_config_bit_a <= 1'b1;
         if (effect_r[4])
            overlay_config_bit_b <= 1'b1;
         if (effect_r[5])
            clk_double_nv_r <= 1'b1;
      end
   end

   // Outputs toward the core
   always @(posedge clk) begin
      if (!rst_n) begin
         overlay_map  <= 1'b0;
         clock_double <= 1'b0;
         code_rd_fail <= 1'b0;
         ext_irq_one  <= 1'b0;
      end else begin
         overlay_map  <= ea_n_r & (flash_config_reg[`DBSP_CFG_OVL_B] |
                                   flash_config_reg[`DBSP_CFG_OVL_A]);
         clock_double <= clk_double_nv_r | (finish & effect_r[5]);
         code_rd_fail <= code_rd_req & busy_r &
                         (chip_op_r | (code_rd_block == arr_block));
         // Pin is only a port pin from the start of an interrupt-terminated command until the next command starts, while the enable bit is set
         if (irq_sel_r && flash_config_reg[`DBSP_CFG_ENABLE])
            ext_irq_one <= finish & ~is_read;
         else
            ext_irq_one <= ~irq_pin_n_r;
      end
   end

endmodule

// *** dbsp_flash_sequencer_chk.sv ***
`timescale 1ns/1ns
`include "dbsp_defines.vh"
module dbsp_flash_sequencer_chk (
   input wire                  clk,             // Clock
   input wire                  rst_n,           // Sync reset
   input wire [4:0]            avs_address,     // Word address
   input wire                  avs_read,        // Read strobe
   input wire                  avs_write,       // Write strobe
   input wire                  avs_waitrequest, // Wait
   input wire                  code_rd_req,     // Code read
   input wire                  code_rd_block,   // Its block
   input wire                  code_rd_fail,    // Refused
   input wire [`DBSP_OP_W-1:0] arr_op,          // Array op
   input wire                  arr_start,       // Start pulse
   input wire                  arr_block,       // Target block
   input wire [15:0]           arr_addr,        // Byte address
   input wire                  arr_done,        // Finished
   input wire                  osc_en           // Oscillator
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A start must trace back to a command write accepted in the cycle before
   reg cmd_wr_q;
   always @(posedge clk) begin
      cmd_wr_q <= avs_write && !avs_waitrequest && avs_address[3:0] == `DBSP_ADDR_COMMAND;
   end
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   a_start_cause: assert property (arr_start |-> cmd_wr_q)
      else $error("start without command write");
   a_start_onehot: assert property (arr_start |-> $onehot(arr_op) ##1 !arr_start)
      else $error("bad start pulse or op");
   a_osc_runs: assert property (arr_start && arr_op != `DBSP_OP_READ |-> osc_en)
      else $error("oscillator off during op");
   a_osc_verify: assert property (arr_start && arr_op == `DBSP_OP_READ |-> !osc_en)
      else $error("oscillator on for verify");
   a_osc_stop: assert property (osc_en && arr_done |=> !osc_en)
      else $error("oscillator not stopped");
   a_osc_hold: assert property (osc_en && !arr_done |=> osc_en)
      else $error("oscillator dropped early");
   a_fail_busy: assert property (code_rd_req && osc_en && !arr_done &&
      code_rd_block == arr_block |=> code_rd_fail)
      else $error("code read not refused");
   a_fail_idle: assert property (code_rd_req && !osc_en |=> !code_rd_fail)
      else $error("code read refused while idle");
   a_op_held: assert property (osc_en && !arr_start |-> $stable(arr_op) && $stable(arr_addr))
      else $error("array request changed");
endmodule
bind dbsp_flash_sequencer dbsp_flash_sequencer_chk u_chk (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .code_rd_req(code_rd_req),
   .code_rd_block(code_rd_block), .code_rd_fail(code_rd_fail), .arr_op(arr_op),
   .arr_start(arr_start), .arr_block(arr_block), .arr_addr(arr_addr),
   .arr_done(arr_done), .osc_en(osc_en));

// *** dbsp_flash_sequencer_tb_top.sv ***
`timescale 1ns/1ns
`include "dbsp_defines.vh"
module dbsp_flash_sequencer_tb_top;
   logic        clk, rst_n, por_n, avs_read, avs_write, avs_waitrequest, ea_n, strap_n, irq_n;
   logic        code_rd_req, code_rd_block, code_rd_fail, arr_start, arr_block, arr_done;
   logic        osc_en, ext_irq_one, overlay_map, boot_bank_select, clock_double;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, seed;
   logic [1:0]  exec_src;
   logic [5:0]  arr_op;
   logic [15:0] arr_addr;
   logic [7:0]  arr_wdata, arr_rdata;
   int          n_mismatch, checked, n_start;
   // Fields: cmd, data, addr high, source, expected op (0 = refused), expected block
   logic [39:0] rows [0:12] = '{
      40'h8B_00_00_0_04_1, 40'h0E_00_00_1_08_0,
      40'h0D_55_00_2_02_0, 40'h0D_55_E0_2_02_1,
      40'h8C_00_00_0_10_1, 40'h81_55_00_2_01_0,
      40'h09_AA_AA_2_20_0, 40'h09_AA_5A_1_20_0,
      40'h08_AA_55_2_20_0, 40'h03_AA_00_2_20_0,
      40'h0D_55_00_1_00_0, 40'h0D_55_00_0_02_1,
      40'h03_AA_00_2_00_0};
   dbsp_flash_sequencer u_dut (.clk(clk), .rst_n(rst_n), .por_n(por_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .exec_src(exec_src), .external_access_pin_n(ea_n),
      .self_program_disable_pin_n(strap_n), .ext_irq_one_pin_n(irq_n),
      .code_rd_req(code_rd_req), .code_rd_block(code_rd_block), .code_rd_fail(code_rd_fail),
      .arr_op(arr_op), .arr_start(arr_start), .arr_block(arr_block), .arr_addr(arr_addr),
      .arr_wdata(arr_wdata), .arr_done(arr_done), .arr_rdata(arr_rdata), .osc_en(osc_en),
      .ext_irq_one(ext_irq_one), .overlay_map(overlay_map),
      .boot_bank_select(boot_bank_select), .clock_double(clock_double));
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // The start pulse is over before the command write task returns, so count it here
   always @(posedge clk)
      if (arr_start === 1'h1) n_start <= n_start + 1;
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int k;
      avs_address <= {1'h0, a};
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'h0 && k < 50);
      q = avs_readdata;
      if (k >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h0, a, 8'h00, q);
      check(nm, q, exp);
   endtask
   task automatic run_row(input logic [39:0] r);
      logic [7:0] ah, al, d, rv;
      logic [5:0] op;
      logic       sh;
      int         k, s0;
      op = r[9:4];
      sh = op == `DBSP_OP_SECTOR || op == `DBSP_OP_PROGRAM || op == `DBSP_OP_READ;
      al = rnd();
      ah = sh ? rnd() : r[23:16];
      d = (op == `DBSP_OP_PROGRAM) ? rnd() : r[31:24];
      exec_src <= r[13:12];
      wr(`DBSP_ADDR_ADDR_LOW, al);
      wr(`DBSP_ADDR_ADDR_HIGH, ah);
      wr(`DBSP_ADDR_DATA, d);
      s0 = n_start;
      wr(`DBSP_ADDR_COMMAND, r[39:32]);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (n_start == s0 && k < 12);
      check("start", 32'(n_start != s0), 32'(op != 6'h00));
      if (op == 6'h00) begin
         rd_chk("idle status", `DBSP_ADDR_STATUS, {24'h000000, strap_n ? 8'h00 : 8'h80});
         return;
      end
      // Pin pulled low while an interrupt-terminated command runs must not show
      irq_n <= !r[39];
      check("op", 32'(arr_op), 32'(op));
      if (op != `DBSP_OP_CFG && op != `DBSP_OP_CHIP) check("block", 32'(arr_block), 32'(r[0]));
      if (sh) check("addr", 32'(arr_addr), {16'h0000, ah, al});
      if (op == `DBSP_OP_PROGRAM) check("wdata", 32'(arr_wdata), 32'(d));
      // Config-bit ops carry no meaningful block, so the refusal probe skips them
      if (op != `DBSP_OP_CFG) begin
         code_rd_block <= r[0];
         code_rd_req <= 1'h1;
         @(posedge clk);
         code_rd_req <= 1'h0;
         @(posedge clk);
         check("code read fail", 32'(code_rd_fail), 32'(op != `DBSP_OP_READ));
      end
      rd_chk("busy", `DBSP_ADDR_STATUS, (op != `DBSP_OP_READ) ? 32'h4 : 32'h0);
      rv = rnd();
      arr_rdata <= rv;
      arr_done <= 1'h1;
      @(posedge clk);
      arr_done <= 1'h0;
      k = 0;
      repeat (3) begin
         @(posedge clk);
         k += (ext_irq_one === 1'h1);
      end
      check("irq pulses", 32'(k), 32'(r[39] && op != `DBSP_OP_READ));
      irq_n <= 1'h1;
      rd_chk("done", `DBSP_ADDR_STATUS, 32'h0);
      if (op == `DBSP_OP_READ) rd_chk("verify data", `DBSP_ADDR_DATA, {24'h000000, rv});
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      seed = 32'h00000050;
      {rst_n, por_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {exec_src, ea_n, strap_n, code_rd_req, code_rd_block, arr_done, arr_rdata} = 15'h0800;
      irq_n = 1'h1;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      por_n <= 1'h1;
      @(posedge clk);
      rd_chk("status", `DBSP_ADDR_STATUS, 32'h0);
      rd_chk("config", `DBSP_ADDR_CONFIG, 32'h0);
      rd_chk("unmapped", 4'h7, 32'h0);
      run_row(40'h0B_00_00_0_00_0);
      wr(`DBSP_ADDR_CONFIG, 8'h40);
      foreach (rows[i]) run_row(rows[i]);
      rd_chk("kept bits", `DBSP_ADDR_NVSTAT, 32'h72);
      check("bank select", 32'(boot_bank_select), 32'h0);
      check("clock double", 32'(clock_double), 32'h1);
      // Strap is only sampled while reset is held, so it is set up before reset
      ea_n <= 1'h1;
      strap_n <= 1'h0;
      rst_n <= 1'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      check("bank select", 32'(boot_bank_select), 32'h1);
      rd_chk("status", `DBSP_ADDR_STATUS, 32'h80);
      rd_chk("config", `DBSP_ADDR_CONFIG, 32'h02);
      check("overlay map", 32'(overlay_map), 32'h1);
      wr(`DBSP_ADDR_CONFIG, 8'h42);
      run_row(40'h0B_00_00_0_00_0);
      ea_n <= 1'h0;
      irq_n <= 1'h0;
      repeat (6) @(posedge clk);
      check("overlay map", 32'(overlay_map), 32'h0);
      check("irq pin", 32'(ext_irq_one), 32'h1);
      report_and_stop();
   end
endmodule
